// *** logic/sfmc_ctrl.v ***
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`include "sfmc_consts.vh"
module sfmc_ctrl #(
  parameter ADDR_W = 8,
  parameter DIV_W  = 8
) (
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire [2:0]        s_axi_awprot,
  input  wire              s_axi_awvalid,
  output reg               s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output reg               s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire [2:0]        s_axi_arprot,
  input  wire              s_axi_arvalid,
  output reg               s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  output wire              spi_sclk,
  output wire              spi_ss_n,
  output wire              spi_so_o,
  output reg               spi_so_oe,
  input  wire              spi_so_i,
  input  wire              spi_si,
  output reg               irq,
  output wire [7:0]        flash_read_opcode,
  output reg  [1:0]        read_mode,
  output wire              cipher_cmd_phase,
  output wire              bus_master_disable,
  output wire              rom_boot_page_write_enable,
  output wire              flash_read_direction,
  output wire              flash_type_512k,
  output wire              dummy_insert,
  output reg               dma_master_enable,
  output reg               dma_flash_to_mem,
  output reg               dma_mem_to_flash
);
  reg  [31:0]       ctrl_reg;
  reg  [31:0]       ctrl_next;
  reg  [DIV_W-1:0]  div_reg;
  reg  [31:0]       tx_mem [0:3];
  reg               start_reg;
  reg               aw_hold_reg;
  reg  [ADDR_W-1:0] aw_addr_reg;
  reg               w_hold_reg;
  reg  [31:0]       w_data_reg;
  reg  [3:0]        w_strb_reg;
  reg  [1:0]        si_sync_reg;
  reg  [1:0]        so_sync_reg;
  reg  [31:0]       rd_word;
  reg  [1:0]        rd_resp;
  integer           i;

  wire [127:0] tx_flat;
  wire [127:0] rx_flat;
  wire         eng_busy;
  wire         eng_done;
  wire         aw_take  = s_axi_awvalid & s_axi_awready;
  wire         w_take   = s_axi_wvalid & s_axi_wready;
  wire         ar_take  = s_axi_arvalid & s_axi_arready;
  wire         do_write = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
  wire [7:0]   wa       = aw_addr_reg[7:0];
  wire [7:0]   ra       = s_axi_araddr[7:0];
  wire         wr_ctrl  = do_write & (wa == `SFMC_OFS_CTRL);
  wire         wr_div   = do_write & (wa == `SFMC_OFS_DIV);
  wire         wr_tx    = do_write & (wa[7:4] == `SFMC_OFS_TX_BASE)
                          & (wa[1:0] == 2'h0);
  wire         wr_rx    = do_write & (wa[7:4] == `SFMC_OFS_RX_BASE)
                          & (wa[1:0] == 2'h0);
  wire [31:0]  wr_old   = wr_ctrl ? ctrl_reg :
                          wr_div  ? {{(32-DIV_W){1'b0}}, div_reg} :
                                    tx_mem[wa[3:2]];
  wire [31:0]  wr_merged;
  wire         dual_rx  = (ctrl_reg[`SFMC_OPC_HI:`SFMC_OPC_LO]
                          == `SFMC_OPC_DUAL) & ctrl_reg[`SFMC_BIT_OEN];

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_lane
      assign wr_merged[8*g +: 8] = w_strb_reg[g] ? w_data_reg[8*g +: 8]
                                                 : wr_old[8*g +: 8];
      assign tx_flat[32*g +: 32] = tx_mem[g];
    end
  endgenerate

  assign flash_read_opcode          = ctrl_reg[`SFMC_OPC_HI:`SFMC_OPC_LO];
  assign cipher_cmd_phase           = ctrl_reg[`SFMC_BIT_CMD];
  assign bus_master_disable         = ctrl_reg[`SFMC_BIT_DISM];
  assign rom_boot_page_write_enable = ctrl_reg[`SFMC_BIT_BOOT];
  assign flash_read_direction       = ctrl_reg[`SFMC_BIT_FDRD];
  assign flash_type_512k            = ctrl_reg[`SFMC_BIT_FTYPE];
  assign dummy_insert               = ctrl_reg[`SFMC_BIT_DUMMY];

  // control word update; hardware flag set beats the software clear
  always @* begin
    ctrl_next = ctrl_reg;
    if (wr_ctrl) begin
      ctrl_next = (wr_merged & `SFMC_CTRL_WMASK)
                | (ctrl_reg & ~`SFMC_CTRL_WMASK);
      if (w_strb_reg[0] & w_data_reg[`SFMC_BIT_GO])
        ctrl_next[`SFMC_BIT_GO] = 1'b1;
      if (w_strb_reg[2] & w_data_reg[`SFMC_BIT_FLAG])
        ctrl_next[`SFMC_BIT_FLAG] = 1'b0;
    end
    if (eng_done) begin
      ctrl_next[`SFMC_BIT_GO] = 1'b0;
      if (ctrl_reg[`SFMC_BIT_IE])
        ctrl_next[`SFMC_BIT_FLAG] = 1'b1;
    end
    ctrl_next[`SFMC_BIT_TXNEG] = 1'b1;
  end

  always @* begin
    rd_word = 32'h00000000;
    rd_resp = `SFMC_RESP_OKAY;
    if (ra[1:0] != 2'h0)
      rd_resp = `SFMC_RESP_SLVERR;
    else if (ra == `SFMC_OFS_CTRL)
      rd_word = ctrl_reg;
    else if (ra == `SFMC_OFS_DIV)
      rd_word = {{(32-DIV_W){1'b0}}, div_reg};
    else if (ra[7:4] == `SFMC_OFS_RX_BASE)
      rd_word = rx_flat[{ra[3:2], 5'h00} +: 32];
    else if (ra[7:4] == `SFMC_OFS_TX_BASE)
      rd_word = tx_mem[ra[3:2]];
    else
      rd_resp = `SFMC_RESP_SLVERR;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg    <= `SFMC_CTRL_RST;
      div_reg     <= `SFMC_DIV_RST;
      start_reg   <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        tx_mem[i] <= 32'h00000000;
    end else begin
      ctrl_reg  <= ctrl_next;
      // start only from idle, so a write while busy cannot restart
      start_reg <= wr_ctrl & w_strb_reg[0] & w_data_reg[`SFMC_BIT_GO]
                   & ~ctrl_reg[`SFMC_BIT_GO] & ~eng_busy;
      if (wr_div)
        div_reg <= wr_merged[DIV_W-1:0];
      if (wr_tx)
        tx_mem[wa[3:2]] <= wr_merged;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `SFMC_RESP_OKAY;
      aw_hold_reg   <= 1'b0;
      aw_addr_reg   <= {ADDR_W{1'b0}};
      w_hold_reg    <= 1'b0;
      w_data_reg    <= 32'h00000000;
      w_strb_reg    <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (do_write) begin
        aw_hold_reg <= 1'b0;
      end
      if (w_take) begin
        w_hold_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (do_write) begin
        w_hold_reg <= 1'b0;
      end
      s_axi_awready <= ~(aw_take | (aw_hold_reg & ~do_write));
      s_axi_wready  <= ~(w_take | (w_hold_reg & ~do_write));
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_ctrl | wr_div | wr_tx | wr_rx)
                        ? `SFMC_RESP_OKAY : `SFMC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `SFMC_RESP_OKAY;
    end else begin
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        s_axi_rresp  <= rd_resp;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= ~(ar_take | (s_axi_rvalid & ~s_axi_rready));
    end
  end

  // pin inputs pass two flops before the engine reads them
  always @(posedge aclk) begin
    if (!aresetn) begin
      si_sync_reg <= 2'h0;
      so_sync_reg <= 2'h0;
    end else begin
      si_sync_reg <= {si_sync_reg[0], spi_si};
      so_sync_reg <= {so_sync_reg[0], spi_so_i};
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      spi_so_oe         <= 1'b0;
      irq               <= 1'b0;
      read_mode         <= `SFMC_MODE_NONE;
      dma_master_enable <= 1'b0;
      dma_flash_to_mem  <= 1'b0;
      dma_mem_to_flash  <= 1'b0;
    end else begin
      spi_so_oe <= ~ctrl_reg[`SFMC_BIT_OEN];
      irq       <= ctrl_reg[`SFMC_BIT_FLAG]
                   & ctrl_reg[`SFMC_BIT_IE];
      case (ctrl_reg[`SFMC_OPC_HI:`SFMC_OPC_LO])
        `SFMC_OPC_STD:  read_mode <= `SFMC_MODE_STD;
        `SFMC_OPC_FAST: read_mode <= `SFMC_MODE_FAST;
        `SFMC_OPC_DUAL: read_mode <= `SFMC_MODE_DUAL;
        default:        read_mode <= `SFMC_MODE_NONE;
      endcase
      dma_master_enable <= ctrl_reg[`SFMC_BIT_BOOT]
                           & ~ctrl_reg[`SFMC_BIT_DISM];
      dma_flash_to_mem  <= ctrl_reg[`SFMC_BIT_BOOT]
                           & ctrl_reg[`SFMC_BIT_FDRD];
      dma_mem_to_flash  <= ctrl_reg[`SFMC_BIT_BOOT]
                           & ~ctrl_reg[`SFMC_BIT_FDRD];
    end
  end

  sfmc_shifter #(
    .DIV_W (DIV_W)
  ) u_shifter (
    .clk     (aclk),
    .rst_n   (aresetn),
    .start   (start_reg),
    .div     (div_reg),
    .bit_len (ctrl_reg[`SFMC_LEN_HI:`SFMC_LEN_LO]),
    .words   (ctrl_reg[`SFMC_NUM_HI:`SFMC_NUM_LO]),
    .sleep   (ctrl_reg[`SFMC_SLEEP_HI:`SFMC_SLEEP_LO]),
    .lsb     (ctrl_reg[`SFMC_BIT_LSB]),
    .receive_edge_select  (ctrl_reg[`SFMC_BIT_RXNEG]),
    .dual    (dual_rx),
    .tx_flat (tx_flat),
    .si      (si_sync_reg[1]),
    .so_in   (so_sync_reg[1]),
    .sclk    (spi_sclk),
    .ss_n    (spi_ss_n),
    .mosi    (spi_so_o),
    .busy    (eng_busy),
    .done    (eng_done),
    .rx_flat (rx_flat)
  );
endmodule

// *** inc/sfmc_consts.vh ***
`ifndef SFMC_CONSTS_VH
`define SFMC_CONSTS_VH
`define SFMC_OFS_CTRL     8'h00
`define SFMC_OFS_DIV      8'h04
`define SFMC_OFS_RX_BASE  4'h1
`define SFMC_OFS_TX_BASE  4'h2
`define SFMC_CTRL_RST     32'h00000004
`define SFMC_CTRL_WMASK   32'hfffefffa
`define SFMC_DIV_RST      8'h00
`define SFMC_OPC_HI       31
`define SFMC_OPC_LO       24
`define SFMC_BIT_OEN      23
`define SFMC_BIT_CMD      22
`define SFMC_BIT_DISM     21
`define SFMC_BIT_BOOT     20
`define SFMC_BIT_FDRD     19
`define SFMC_BIT_FTYPE    18
`define SFMC_BIT_IE       17
`define SFMC_BIT_FLAG     16
`define SFMC_SLEEP_HI     15
`define SFMC_SLEEP_LO     12
`define SFMC_BIT_DUMMY    11
`define SFMC_BIT_LSB      10
`define SFMC_NUM_HI       9
`define SFMC_NUM_LO       8
`define SFMC_LEN_HI       7
`define SFMC_LEN_LO       3
`define SFMC_BIT_TXNEG    2
`define SFMC_BIT_RXNEG    1
`define SFMC_BIT_GO       0
`define SFMC_OPC_STD      8'h03
`define SFMC_OPC_FAST     8'h0b
`define SFMC_OPC_DUAL     8'h3b
`define SFMC_MODE_STD     2'h0
`define SFMC_MODE_FAST    2'h1
`define SFMC_MODE_DUAL    2'h2
`define SFMC_MODE_NONE    2'h3
`define SFMC_GAP_EXTRA    6'h03
`define SFMC_FULL_LEN     6'h20
`define SFMC_RESP_OKAY    2'h0
`define SFMC_RESP_SLVERR  2'h2
`endif

// *** logic/sfmc_shifter.v ***
`timescale 1ns/100ps
`include "sfmc_consts.vh"
module sfmc_shifter #(
  parameter DIV_W = 8
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire             start,
  input  wire [DIV_W-1:0] div,
  input  wire [4:0]       bit_len,
  input  wire [1:0]       words,
  input  wire [3:0]       sleep,
  input  wire             lsb,
  input  wire             receive_edge_select,
  input  wire             dual,
  input  wire [127:0]     tx_flat,
  input  wire             si,
  input  wire             so_in,
  output reg              sclk,
  output reg              ss_n,
  output reg              mosi,
  output reg              busy,
  output reg              done,
  output wire [127:0]     rx_flat
);
  localparam ST_IDLE  = 2'h0;
  localparam ST_SHIFT = 2'h1;
  localparam ST_GAP   = 2'h2;

  reg [1:0]       state_reg;
  reg [DIV_W-1:0] hcnt_reg;
  reg [31:0]      sh_reg;
  reg [31:0]      rxs_reg;
  reg [5:0]       cnt_reg;
  reg [1:0]       widx_reg;
  reg [5:0]       gcnt_reg;
  reg [31:0]      rx_mem [0:3];
  integer         i;

  wire [5:0] len6 = (bit_len == 5'h00) ? `SFMC_FULL_LEN : {1'b0, bit_len};
  wire [5:0] step = dual ? 6'h02 : 6'h01;
  wire       tick = (hcnt_reg == div);

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_rx
      assign rx_flat[32*g +: 32] = rx_mem[g];
    end
  endgenerate

  function [31:0] align;
    input [1:0] idx;
    reg   [31:0] w;
    begin
      w = tx_flat[{idx, 5'h00} +: 32];
      align = lsb ? w : (w << (`SFMC_FULL_LEN - len6));
    end
  endfunction

  // dual mode takes two bits per clock, so line first
  function [31:0] shin;
    input [31:0] v;
    begin
      if (dual)
        shin = lsb ? {si, so_in, v[31:2]} : {v[29:0], so_in, si};
      else
        shin = lsb ? {si, v[31:1]} : {v[30:0], si};
    end
  endfunction

  function [31:0] fix;
    input [31:0] v;
    begin
      fix = lsb ? (v >> (`SFMC_FULL_LEN - len6)) : v;
    end
  endfunction

  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      hcnt_reg  <= {DIV_W{1'b0}};
      sh_reg    <= 32'h00000000;
      rxs_reg   <= 32'h00000000;
      cnt_reg   <= 6'h00;
      widx_reg  <= 2'h0;
      gcnt_reg  <= 6'h00;
      sclk      <= 1'b0;
      ss_n      <= 1'b1;
      mosi      <= 1'b0;
      busy      <= 1'b0;
      done      <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        rx_mem[i] <= 32'h00000000;
    end else begin
      done <= 1'b0;
      mosi <= lsb ? sh_reg[0] : sh_reg[31];
      case (state_reg)
        ST_IDLE: begin
          hcnt_reg <= {DIV_W{1'b0}};
          if (start) begin
            busy      <= 1'b1;
            ss_n      <= 1'b0;
            widx_reg  <= 2'h0;
            sh_reg    <= align(2'h0);
            cnt_reg   <= len6;
            rxs_reg   <= 32'h00000000;
            state_reg <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          hcnt_reg <= tick ? {DIV_W{1'b0}} : hcnt_reg + 1'b1;
          if (tick) begin
            sclk <= ~sclk;
            if (!sclk) begin
              if (!receive_edge_select)
                rxs_reg <= shin(rxs_reg);
            end else if (cnt_reg <= step) begin
              rx_mem[widx_reg] <= fix(receive_edge_select ? shin(rxs_reg) : rxs_reg);
              if (widx_reg == words) begin
                // single-word transfer never enters the gap
                state_reg <= ST_IDLE;
                busy      <= 1'b0;
                ss_n      <= 1'b1;
                done      <= 1'b1;
              end else begin
                // gap from last fall to next rise
                gcnt_reg  <= {1'b0, sleep, 1'b0} + `SFMC_GAP_EXTRA;
                widx_reg  <= widx_reg + 2'h1;
                state_reg <= ST_GAP;
              end
            end else begin
              cnt_reg <= cnt_reg - step;
              sh_reg  <= lsb ? (sh_reg >> 1) : (sh_reg << 1);
              if (receive_edge_select)
                rxs_reg <= shin(rxs_reg);
            end
          end
        end
        ST_GAP: begin
          hcnt_reg <= tick ? {DIV_W{1'b0}} : hcnt_reg + 1'b1;
          if (tick) begin
            gcnt_reg <= gcnt_reg - 6'h01;
            if (gcnt_reg == 6'h01) begin
              sh_reg    <= align(widx_reg);
              cnt_reg   <= len6;
              rxs_reg   <= 32'h00000000;
              state_reg <= ST_SHIFT;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end
endmodule

// *** dv/sfmc_assertions.sv ***
`timescale 1ns/100ps
module sfmc_assertions (
  input wire        aclk,
  input wire        aresetn,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire [1:0]  s_axi_bresp,
  input wire        spi_sclk,
  input wire        spi_ss_n,
  input wire        irq,
  input wire [7:0]  flash_read_opcode,
  input wire [1:0]  read_mode,
  input wire        bus_master_disable,
  input wire        rom_boot_page_write_enable,
  input wire        flash_read_direction,
  input wire        dma_master_enable,
  input wire        dma_flash_to_mem,
  input wire        dma_mem_to_flash
);
  wire       rom;
  wire [7:0] op;
  assign rom = rom_boot_page_write_enable;
  assign op  = flash_read_opcode;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read late");
  property p_rd_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("rdata moved");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("bresp moved");
  property p_mode;
    $stable(op) |-> read_mode == (op == 8'h03 ? 2'h0 : op == 8'h0b ? 2'h1 :
      op == 8'h3b ? 2'h2 : 2'h3);
  endproperty
  a_mode: assert property (p_mode) else $error("read mode wrong");
  property p_dma_en;
    $stable({rom, bus_master_disable}) |->
      dma_master_enable == (rom && !bus_master_disable);
  endproperty
  a_dma_en: assert property (p_dma_en) else $error("dma enable");
  property p_f2m;
    $stable({rom, flash_read_direction}) |->
      dma_flash_to_mem == (rom && flash_read_direction);
  endproperty
  a_f2m: assert property (p_f2m) else $error("flash to mem");
  property p_m2f;
    $stable({rom, flash_read_direction}) |->
      dma_mem_to_flash == (rom && !flash_read_direction);
  endproperty
  a_m2f: assert property (p_m2f) else $error("mem to flash");
  property p_sclk_idle;
    spi_ss_n |-> !spi_sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle) else $error("sclk idle");
  property p_irq;
    $rose(irq) |-> spi_ss_n && $past(spi_ss_n);
  endproperty
  a_irq: assert property (p_irq) else $error("irq early");
  c_irq: cover property ($rose(irq));
  c_dual: cover property (read_mode == 2'h2 && !spi_ss_n);
  c_f2m: cover property (dma_flash_to_mem);
endmodule
bind sfmc_ctrl sfmc_assertions sfmc_assertions_inst (.aclk, .aresetn,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .spi_sclk,
  .spi_ss_n, .irq, .flash_read_opcode, .read_mode, .bus_master_disable,
  .rom_boot_page_write_enable, .flash_read_direction, .dma_master_enable,
  .dma_flash_to_mem, .dma_mem_to_flash);

// *** dv/sfmc_flash_model.sv ***
`timescale 1ns/100ps
module sfmc_flash_model #(
  parameter [31:0] PAT    = 32'hc3a55a3c,
  parameter        CLK_NS = 20
) (
  input  wire aclk,
  input  wire spi_sclk,
  input  wire spi_ss_n,
  input  wire spi_so_o,
  input  wire spi_so_oe,
  output wire spi_si,
  output wire spi_so_i
);
  reg [31:0] resp_reg = PAT;
  reg [31:0] mosi_reg = 32'h0;
  reg        tog_reg = 1'b0;
  integer    rises = 0;
  integer    gap_max = 0;
  time       fall_t = 0;
  always @(posedge aclk) tog_reg <= ~tog_reg;
  // released spi_si keeps toggling; spi_so_i toggles only while spi_so_oe is low, else it loops back spi_so_o
  assign spi_si = spi_ss_n ? tog_reg : resp_reg[spi_so_oe ? 31 : 30];
  // dual read: flash drives the serial-out wire as well
  assign spi_so_i = spi_so_oe ? spi_so_o
                              : (spi_ss_n ? ~tog_reg : resp_reg[31]);
  always @(posedge spi_ss_n or negedge spi_sclk) begin
    if (spi_ss_n) resp_reg <= PAT;
    else begin
      resp_reg <= spi_so_oe ? resp_reg << 1 : resp_reg << 2;
      fall_t = $time;
    end
  end
  always @(negedge spi_ss_n or posedge spi_sclk) begin
    if (spi_sclk) begin
      rises = rises + 1;
      mosi_reg = {mosi_reg[30:0], spi_so_o};
      if (rises > 1 && ($time - fall_t) / CLK_NS > gap_max)
        gap_max = ($time - fall_t) / CLK_NS;
    end else begin
      rises = 0;
      gap_max = 0;
    end
  end
endmodule

// *** dv/tb_top.sv ***
`timescale 1ns/100ps
`include "sfmc_consts.vh"
`define CHK(a, e) begin compares = compares + 1; if ((a) !== (e)) begin \
  error_cnt = error_cnt + 1; \
  $display("mismatch %0t got %0h want %0h", $time, (a), (e)); end end
module tb_top;
  reg         aclk = 1'b0;
  reg         aresetn = 1'b0;
  reg  [7:0]  s_axi_awaddr = 8'h00;
  reg         s_axi_awvalid = 1'b0;
  reg  [31:0] s_axi_wdata = 32'h0;
  reg         s_axi_wvalid = 1'b0;
  reg         s_axi_bready = 1'b0;
  reg  [7:0]  s_axi_araddr = 8'h00;
  reg         s_axi_arvalid = 1'b0;
  reg         s_axi_rready = 1'b0;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire        s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp, read_mode;
  wire [31:0] s_axi_rdata;
  wire [7:0]  flash_read_opcode;
  wire        spi_sclk, spi_ss_n, spi_so_o, spi_so_oe, spi_so_i, spi_si;
  wire        irq, cipher_cmd_phase, bus_master_disable, dummy_insert;
  wire        rom_boot_page_write_enable, flash_read_direction;
  wire        flash_type_512k, dma_master_enable;
  wire        dma_flash_to_mem, dma_mem_to_flash;
  integer     error_cnt = 0;
  integer     compares = 0;
  integer     i;
  reg  [31:0] rd;
  reg  [31:0] v;
  reg  [1:0]  last_resp;
  reg  [7:0]  op_t [0:3] = '{8'h03, 8'h0b, 8'h3b, 8'h7e};
  reg  [1:0]  md_t [0:3] = '{2'h0, 2'h1, 2'h2, 2'h3};
  reg  [7:0]  fl_t [0:3] = '{8'hfc, 8'h00, 8'ha8, 8'h54};
  reg  [31:0] tx_t [0:3] = '{32'h123456a5, 32'h9, 32'h2468ace1, 32'h9bdf1357};
  reg  [31:0] ct_t [0:3] = '{32'h2f040, 32'h120, 32'h22300, 32'h3b820040};
  reg  [31:0] rx_t [0:3] = '{32'hc3, 32'hc, 32'hc3a55a3c, 32'hc3};
  reg  [31:0] ex_t [0:3] = '{32'ha5, 32'h9, 32'h9bdf1357, 32'h0};
  reg  [31:0] mk_t [0:3] = '{32'hff, 32'hf, 32'hffffffff, 32'h0};
  integer     rs_t [0:3] = '{8, 8, 128, 4};
  integer     gp_t [0:3] = '{6, 24, 48, 6};
  sfmc_ctrl sfmc_ctrl_inst (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .spi_sclk, .spi_ss_n, .spi_so_o,
    .spi_so_oe, .spi_so_i, .spi_si, .irq, .flash_read_opcode, .read_mode,
    .cipher_cmd_phase, .bus_master_disable, .rom_boot_page_write_enable,
    .flash_read_direction, .flash_type_512k, .dummy_insert,
    .dma_master_enable, .dma_flash_to_mem, .dma_mem_to_flash);
  sfmc_flash_model sfmc_flash_model_inst (.aclk, .spi_sclk, .spi_ss_n,
    .spi_so_o, .spi_so_oe, .spi_si, .spi_so_i);
  always #10 aclk = ~aclk;
  task automatic axi_wr(input [7:0] a, input [31:0] d);
    reg fa;
    reg fw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fa = 1'b0;
    fw = 1'b0;
    while (!(fa && fw)) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      fa = fa || s_axi_awready === 1'b1;
      fw = fw || s_axi_wready === 1'b1;
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    last_resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input [7:0] a, output [31:0] d);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    last_resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task end_of_test;
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    #(20 * 30000);
    error_cnt = error_cnt + 1;
    end_of_test;
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`SFMC_OFS_CTRL, rd);
    `CHK(rd, `SFMC_CTRL_RST)
    axi_rd(8'h0c, rd);
    `CHK(last_resp, `SFMC_RESP_SLVERR)
    axi_wr(8'h0c, 32'hffffffff);
    `CHK(last_resp, `SFMC_RESP_SLVERR)
    for (i = 0; i < 4; i++) begin
      v = {op_t[i], fl_t[i], 16'h0000};
      axi_wr(`SFMC_OFS_CTRL, v);
      axi_rd(`SFMC_OFS_CTRL, rd);
      `CHK(rd, v | 32'h4)
      `CHK(({flash_read_opcode, read_mode}), ({op_t[i], md_t[i]}))
      `CHK(({spi_so_oe, cipher_cmd_phase, flash_type_512k, bus_master_disable,
        rom_boot_page_write_enable, flash_read_direction}),
        ({~v[23], v[22], v[18], v[21:19]}))
      `CHK(({dma_master_enable, dma_flash_to_mem, dma_mem_to_flash}),
        ({v[20] & ~v[21], v[20] & v[19], v[20] & ~v[19]}))
    end
    axi_wr(`SFMC_OFS_CTRL, 32'h0b300800);
    axi_rd(`SFMC_OFS_CTRL, rd);
    `CHK(rd, 32'h0b300804)
    `CHK(({dummy_insert, dma_master_enable, dma_mem_to_flash}), 3'h5)
    axi_wr(`SFMC_OFS_DIV, 32'h5);
    `CHK(last_resp, `SFMC_RESP_OKAY)
    for (i = 0; i < 4; i++) axi_wr(8'(8'h20 + 4 * i), tx_t[i]);
    for (i = 0; i < 4; i++) begin
      axi_wr(`SFMC_OFS_CTRL, ct_t[i]);
      axi_wr(`SFMC_OFS_CTRL, ct_t[i] | 32'h1);
      rd = 32'h1;
      while (rd[0] === 1'b1) begin
        axi_rd(`SFMC_OFS_CTRL, rd);
        if (rd[0] === 1'b1) `CHK(rd[16], 1'b0)
      end
      `CHK(rd, ct_t[i] | 32'h4 | {ct_t[i][17], 16'h0})
      `CHK(irq, ct_t[i][17])
      `CHK(sfmc_flash_model_inst.rises, rs_t[i])
      `CHK(sfmc_flash_model_inst.gap_max, gp_t[i])
      `CHK(sfmc_flash_model_inst.mosi_reg & mk_t[i], ex_t[i])
      axi_rd(8'h10, rd);
      `CHK(rd, rx_t[i])
      axi_wr(`SFMC_OFS_CTRL, ct_t[i]);
      axi_rd(`SFMC_OFS_CTRL, rd);
      `CHK(rd[16], ct_t[i][17])
      axi_wr(`SFMC_OFS_CTRL, ct_t[i] | 32'h10000);
      axi_rd(`SFMC_OFS_CTRL, rd);
      `CHK((rd[16] | irq), 1'b0)
    end
    end_of_test;
  end
endmodule
